// [core/timer01_pkg.sv]
// constants shared by the timer 0/1 block
package timer01_pkg;
  // operating modes (two mode bits, high then low)
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // prescaler select codes
  localparam logic [1:0] PRESC_DIV1 = 2'h0;
  localparam logic [1:0] PRESC_DIV2 = 2'h1;
  localparam logic [1:0] PRESC_DIV4 = 2'h2;
  localparam logic [1:0] PRESC_DIV8 = 2'h3;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRESC = 8'h04;
  localparam logic [7:0] OFS_T0_COUNT = 8'h08;
  localparam logic [7:0] OFS_T1_COUNT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  // control register fields
  localparam int CTRL_T0_MODE_LO = 0;
  localparam int CTRL_T0_SRC = 2;
  localparam int CTRL_T0_GATE = 3;
  localparam int CTRL_T0_RUN = 4;
  localparam int CTRL_T1_MODE_LO = 8;
  localparam int CTRL_T1_SRC = 10;
  localparam int CTRL_T1_GATE = 11;
  localparam int CTRL_T1_RUN = 12;
  // prescale register fields
  localparam int PRESC_T0_LO = 0;
  localparam int PRESC_T1_LO = 2;
  // count register fields
  localparam int COUNT_LOW_LO = 0;
  localparam int COUNT_HIGH_LO = 8;
  // status and mask fields
  localparam int STAT_T0_OVF = 0;
  localparam int STAT_T1_OVF = 1;
  // reset values
  localparam logic [1:0] RST_PRESC = PRESC_DIV2;
  localparam logic [1:0] RST_MODE = MODE_13BIT;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [1:0] RST_FLAGS = 2'h0;
endpackage

// [core/timer_tick_gen.sv]
// per-timer prescaler and count-source select
`timescale 1ns/1ps
`default_nettype none
module timer_tick_gen
  import timer01_pkg::*;
#(
  parameter int DIV_W = 3
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire logic [1:0] presc_sel,
  input wire logic src_pin,
  // external count pin, synchronous to clk
  input wire logic count_pin,
  // ticks
  output logic int_tick,
  output logic sel_tick
);
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic pin_prev_ff;
  logic nxt_pin_prev;
  logic [DIV_W-1:0] div_mask;

  always_comb
  begin
    unique case (presc_sel)
      PRESC_DIV1: div_mask = DIV_W'(0);
      PRESC_DIV2: div_mask = DIV_W'(1);
      PRESC_DIV4: div_mask = DIV_W'(3);
      PRESC_DIV8: div_mask = DIV_W'(7);
    endcase
    nxt_div = div_ff + DIV_W'(1);
    nxt_pin_prev = count_pin;
    // free-running divider: a ratio change takes effect within one period
    int_tick = (div_ff & div_mask) == DIV_W'(0); // RULE15
    // external events count on a falling edge of the pin
    sel_tick = src_pin ? (pin_prev_ff & ~count_pin) : int_tick; // RULE14
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_ff <= '0;
      pin_prev_ff <= 1'b0;
    end
    else
    begin
      div_ff <= nxt_div;
      pin_prev_ff <= nxt_pin_prev;
    end
  end
endmodule
`default_nettype wire

// [core/timer01.sv]
// timer/counter 0 and 1 with APB registers, overflow interrupt and baud tick
// Behaviour
// RULE1 - mode 1 counts through all sixteen bits of high and low byte
// RULE2 - mode 2 runs only the low byte as an 8-bit reloading counter
// RULE3 - mode 2 low byte overflow sets flag and reloads low from high
// RULE4 - mode 2 reload leaves the high byte untouched
// RULE5 - timer 1 in mode 3 holds its count, like run bit cleared
// RULE6 - timer 0 in mode 3 splits into two separate 8-bit counters
// RULE7 - timer 0 split low byte uses timer 0 source, gate, run, flag
// RULE8 - timer 0 split high byte: timer only, timer 1 run and flag
// RULE9 - timer 1 interrupt comes from timer 0 high byte while split
// RULE10 - while split, timer 1 stops in mode 3, restarts in others
// RULE11 - while split, timer 1 still feeds baud tick, no interrupt
// RULE12 - mode 0 is 13 bits: high byte plus low five bits, wrap flags
// RULE13 - counting passes only if run and (gate off or gate pin high)
// RULE14 - source select picks pin edges when set, prescaled clock when clear
// RULE15 - two-bit prescaler gives 1:1, 1:2, 1:4, 1:8; 1:2 after reset
// RULE16 - split high byte ignores source and gate, counts when timer 1 runs
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module timer01
  import timer01_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external pins, synchronous to clk
  input wire logic t0_count_pin,
  input wire logic t1_count_pin,
  input wire logic external_pin0_qualifier,
  input wire logic external_pin1_qualifier,
  // outputs
  output logic irq,
  output logic t1_baud_tick
);
  logic [1:0] t0_mode_ff, t1_mode_ff, nxt_t0_mode, nxt_t1_mode;
  logic t0_src_ff, t1_src_ff, nxt_t0_src, nxt_t1_src;
  logic t0_gate_ff, t1_gate_ff, nxt_t0_gate, nxt_t1_gate;
  logic t0_run_bit, t1_run_bit, nxt_t0_run, nxt_t1_run;
  logic [1:0] t0_prescale_ff, t1_prescale_ff, nxt_t0_prescale, nxt_t1_prescale;
  logic [7:0] t0_low_count, t0_high_count, t1_low_count, t1_high_count;
  logic [7:0] nxt_t0_low, nxt_t0_high, nxt_t1_low, nxt_t1_high;
  logic t0_overflow_flag, t1_overflow_flag, nxt_t0_flag, nxt_t1_flag;
  logic [1:0] mask_ff, nxt_mask;
  logic [31:0] prdata_ff, nxt_prdata;
  logic baud_ff, nxt_baud;
  logic t0_int_tick, t0_sel_tick, t1_sel_tick;
  logic access, setup, addr_ok, wr;
  logic wr_ctrl, wr_presc, wr_t0, wr_t1, wr_stat, wr_mask;
  logic t0_split, t0_en, t1_en, t0_tick, t1_tick, t0h_tick;
  logic t0_ovf, t0h_ovf, t1_ovf;
  logic [16:0] t0_step, t1_step;
  logic [1:0] clr_bits;

  timer_tick_gen u_tick0 (
    .clk(clk),
    .rst(rst),
    .presc_sel(t0_prescale_ff),
    .src_pin(t0_src_ff),
    .count_pin(t0_count_pin),
    .int_tick(t0_int_tick),
    .sel_tick(t0_sel_tick)
  );

  timer_tick_gen u_tick1 (
    .clk(clk),
    .rst(rst),
    .presc_sel(t1_prescale_ff),
    .src_pin(t1_src_ff),
    .count_pin(t1_count_pin),
    .int_tick(),
    .sel_tick(t1_sel_tick)
  );

  // one increment of a timer in a non-split mode: {overflow, high, low}
  function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] hi, input logic [7:0] lo);
    logic [12:0] s13;
    logic [15:0] s16;
    logic [16:0] r;
    s13 = {hi, lo[4:0]} + 13'h0001;
    s16 = {hi, lo} + 16'h0001;
    unique case (m)
      MODE_13BIT: r = {&{hi, lo[4:0]}, s13[12:5], lo[7:5], s13[4:0]}; // RULE12
      MODE_16BIT: r = {&{hi, lo}, s16}; // RULE1
      MODE_RELOAD: r = {&lo, hi, (&lo) ? hi : lo + 8'h01}; // RULE2 RULE3 RULE4
      MODE_SPLIT: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  always_comb
  begin
    setup = psel & ~penable;
    access = psel & penable;
    addr_ok = (paddr == OFS_CTRL) | (paddr == OFS_PRESC) | (paddr == OFS_T0_COUNT) |
              (paddr == OFS_T1_COUNT) | (paddr == OFS_STATUS) | (paddr == OFS_MASK);
    pready = access;
    pslverr = access & ~addr_ok;
    prdata = prdata_ff;
    wr = access & pwrite;
    wr_ctrl = wr & (paddr == OFS_CTRL);
    wr_presc = wr & (paddr == OFS_PRESC);
    wr_t0 = wr & (paddr == OFS_T0_COUNT);
    wr_t1 = wr & (paddr == OFS_T1_COUNT);
    wr_stat = wr & (paddr == OFS_STATUS);
    wr_mask = wr & (paddr == OFS_MASK);
    // read data is captured in the setup cycle so it leaves a flip-flop
    nxt_prdata = prdata_ff;
    if (setup & ~pwrite)
    begin
      nxt_prdata = 32'h0000_0000;
      if (paddr == OFS_CTRL)
      begin
        nxt_prdata[CTRL_T0_MODE_LO +: 2] = t0_mode_ff;
        nxt_prdata[CTRL_T0_SRC] = t0_src_ff;
        nxt_prdata[CTRL_T0_GATE] = t0_gate_ff;
        nxt_prdata[CTRL_T0_RUN] = t0_run_bit;
        nxt_prdata[CTRL_T1_MODE_LO +: 2] = t1_mode_ff;
        nxt_prdata[CTRL_T1_SRC] = t1_src_ff;
        nxt_prdata[CTRL_T1_GATE] = t1_gate_ff;
        nxt_prdata[CTRL_T1_RUN] = t1_run_bit;
      end
      if (paddr == OFS_PRESC)
      begin
        nxt_prdata[PRESC_T0_LO +: 2] = t0_prescale_ff;
        nxt_prdata[PRESC_T1_LO +: 2] = t1_prescale_ff;
      end
      if (paddr == OFS_T0_COUNT)
        nxt_prdata[15:0] = {t0_high_count, t0_low_count};
      if (paddr == OFS_T1_COUNT)
        nxt_prdata[15:0] = {t1_high_count, t1_low_count};
      if (paddr == OFS_STATUS)
      begin
        nxt_prdata[STAT_T0_OVF] = t0_overflow_flag;
        nxt_prdata[STAT_T1_OVF] = t1_overflow_flag;
      end
      if (paddr == OFS_MASK)
        nxt_prdata[1:0] = mask_ff;
    end
  end

  always_comb
  begin
    nxt_t0_mode = t0_mode_ff;
    nxt_t1_mode = t1_mode_ff;
    nxt_t0_src = t0_src_ff;
    nxt_t1_src = t1_src_ff;
    nxt_t0_gate = t0_gate_ff;
    nxt_t1_gate = t1_gate_ff;
    nxt_t0_run = t0_run_bit;
    nxt_t1_run = t1_run_bit;
    nxt_t0_prescale = t0_prescale_ff;
    nxt_t1_prescale = t1_prescale_ff;
    nxt_mask = mask_ff;
    if (wr_ctrl)
    begin
      nxt_t0_mode = pwdata[CTRL_T0_MODE_LO +: 2];
      nxt_t0_src = pwdata[CTRL_T0_SRC];
      nxt_t0_gate = pwdata[CTRL_T0_GATE];
      nxt_t0_run = pwdata[CTRL_T0_RUN];
      nxt_t1_mode = pwdata[CTRL_T1_MODE_LO +: 2];
      nxt_t1_src = pwdata[CTRL_T1_SRC];
      nxt_t1_gate = pwdata[CTRL_T1_GATE];
      nxt_t1_run = pwdata[CTRL_T1_RUN];
    end
    if (wr_presc)
    begin
      nxt_t0_prescale = pwdata[PRESC_T0_LO +: 2];
      nxt_t1_prescale = pwdata[PRESC_T1_LO +: 2];
    end
    if (wr_mask)
      nxt_mask = pwdata[1:0];
  end

  always_comb
  begin
    t0_split = t0_mode_ff == MODE_SPLIT; // RULE6
    t0_en = t0_run_bit & (~t0_gate_ff | external_pin0_qualifier); // RULE13 RULE7
    t0_tick = t0_en & t0_sel_tick;
    // split high byte borrows timer 1's run bit, always on internal clock
    t0h_tick = t0_split & t1_run_bit & t0_int_tick; // RULE8 RULE16
    // while timer 0 is split its high byte owns timer 1's run bit, so timer 1
    // runs on mode alone and is stopped only by its own mode 3
    t1_en = t0_split ? 1'b1 : t1_run_bit & (~t1_gate_ff | external_pin1_qualifier); // RULE10 RULE13
    t1_tick = (t1_mode_ff != MODE_SPLIT) & t1_en & t1_sel_tick; // RULE5
    t0_step = step(t0_mode_ff, t0_high_count, t0_low_count);
    t1_step = step(t1_mode_ff, t1_high_count, t1_low_count);
    nxt_t0_low = t0_low_count;
    nxt_t0_high = t0_high_count;
    nxt_t1_low = t1_low_count;
    nxt_t1_high = t1_high_count;
    t0_ovf = 1'b0;
    t0h_ovf = 1'b0;
    t1_ovf = 1'b0;
    if (t0_split)
    begin
      if (t0_tick)
      begin
        nxt_t0_low = t0_low_count + 8'h01; // RULE7
        t0_ovf = &t0_low_count;
      end
      if (t0h_tick)
      begin
        nxt_t0_high = t0_high_count + 8'h01; // RULE8
        t0h_ovf = &t0_high_count;
      end
    end
    else if (t0_tick)
    begin
      {t0_ovf, nxt_t0_high, nxt_t0_low} = t0_step;
    end
    if (t1_tick)
    begin
      {t1_ovf, nxt_t1_high, nxt_t1_low} = t1_step;
    end
    // a software load wins over a count in the same cycle
    if (wr_t0)
    begin
      nxt_t0_low = pwdata[COUNT_LOW_LO +: 8];
      nxt_t0_high = pwdata[COUNT_HIGH_LO +: 8];
    end
    if (wr_t1)
    begin
      nxt_t1_low = pwdata[COUNT_LOW_LO +: 8];
      nxt_t1_high = pwdata[COUNT_HIGH_LO +: 8];
    end
    clr_bits = wr_stat ? pwdata[1:0] : 2'h0;
    // set wins over a write-one clear in the same cycle
    nxt_t0_flag = t0_ovf | (t0_overflow_flag & ~clr_bits[STAT_T0_OVF]);
    nxt_t1_flag = (t0_split ? t0h_ovf : t1_ovf) | (t1_overflow_flag & ~clr_bits[STAT_T1_OVF]); // RULE9 RULE11
    nxt_baud = t1_ovf; // RULE11
    irq = |({t1_overflow_flag, t0_overflow_flag} & mask_ff);
    t1_baud_tick = baud_ff;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      t0_mode_ff <= RST_MODE;
      t1_mode_ff <= RST_MODE;
      t0_src_ff <= 1'b0;
      t1_src_ff <= 1'b0;
      t0_gate_ff <= 1'b0;
      t1_gate_ff <= 1'b0;
      t0_run_bit <= 1'b0;
      t1_run_bit <= 1'b0;
      t0_prescale_ff <= RST_PRESC; // RULE15
      t1_prescale_ff <= RST_PRESC;
      t0_low_count <= RST_COUNT;
      t0_high_count <= RST_COUNT;
      t1_low_count <= RST_COUNT;
      t1_high_count <= RST_COUNT;
      t0_overflow_flag <= 1'b0;
      t1_overflow_flag <= 1'b0;
      mask_ff <= RST_FLAGS;
      prdata_ff <= 32'h0000_0000;
      baud_ff <= 1'b0;
    end
    else
    begin
      t0_mode_ff <= nxt_t0_mode;
      t1_mode_ff <= nxt_t1_mode;
      t0_src_ff <= nxt_t0_src;
      t1_src_ff <= nxt_t1_src;
      t0_gate_ff <= nxt_t0_gate;
      t1_gate_ff <= nxt_t1_gate;
      t0_run_bit <= nxt_t0_run;
      t1_run_bit <= nxt_t1_run;
      t0_prescale_ff <= nxt_t0_prescale;
      t1_prescale_ff <= nxt_t1_prescale;
      t0_low_count <= nxt_t0_low;
      t0_high_count <= nxt_t0_high;
      t1_low_count <= nxt_t1_low;
      t1_high_count <= nxt_t1_high;
      t0_overflow_flag <= nxt_t0_flag;
      t1_overflow_flag <= nxt_t1_flag;
      mask_ff <= nxt_mask;
      prdata_ff <= nxt_prdata;
      baud_ff <= nxt_baud;
    end
  end

  // quiet cycle: no register write of any kind
  logic quiet;
  assign quiet = ~wr;

  sequence seq_t0_reload;
    (t0_mode_ff == MODE_RELOAD) && t0_tick && (t0_low_count == 8'hff) && quiet;
  endsequence

  sequence seq_t0h_wrap;
    t0_split && t1_run_bit && t0_int_tick && (t0_high_count == 8'hff) && quiet;
  endsequence

  AST_MODE2_RELOAD: assert property (@(posedge clk) disable iff (rst) // RULE3
    seq_t0_reload |=> (t0_low_count == $past(t0_high_count)) && t0_overflow_flag)
    else $error("mode 2 reload or flag missing");

  AST_MODE2_HIGH_KEPT: assert property (@(posedge clk) disable iff (rst) // RULE4
    ((t0_mode_ff == MODE_RELOAD) && quiet) |=> $stable(t0_high_count))
    else $error("mode 2 high byte changed");

  AST_MODE0_WRAP: assert property (@(posedge clk) disable iff (rst) // RULE12
    ((t0_mode_ff == MODE_13BIT) && t0_tick && (t0_high_count == 8'hff) && (t0_low_count[4:0] == 5'h1f) && quiet)
    |=> (t0_high_count == 8'h00) && (t0_low_count[4:0] == 5'h00) && t0_overflow_flag)
    else $error("13-bit wrap wrong");

  AST_MODE1_COUNT: assert property (@(posedge clk) disable iff (rst) // RULE1
    ((t0_mode_ff == MODE_16BIT) && t0_tick && quiet)
    |=> ({t0_high_count, t0_low_count} == $past({t0_high_count, t0_low_count}) + 16'h0001))
    else $error("16-bit count wrong");

  AST_T1_FROZEN: assert property (@(posedge clk) disable iff (rst) // RULE5
    ((t1_mode_ff == MODE_SPLIT) && quiet) |=> $stable({t1_high_count, t1_low_count}))
    else $error("timer 1 moved in mode 3");

  AST_SPLIT_HIGH_FLAG: assert property (@(posedge clk) disable iff (rst) // RULE8
    seq_t0h_wrap |=> (t0_high_count == 8'h00) && t1_overflow_flag)
    else $error("split high byte wrap did not flag");

  AST_SPLIT_T1_NO_FLAG: assert property (@(posedge clk) disable iff (rst) // RULE11
    (t0_split && t1_ovf && ~t0h_ovf && ~t1_overflow_flag) |=> t1_baud_tick && ~t1_overflow_flag)
    else $error("timer 1 flagged while timer 0 split");

  AST_GATE_BLOCKS: assert property (@(posedge clk) disable iff (rst) // RULE13
    ((t0_mode_ff == MODE_16BIT) && (~t0_run_bit || (t0_gate_ff && ~external_pin0_qualifier)) && quiet)
    |=> $stable({t0_high_count, t0_low_count}))
    else $error("timer 0 counted while gated off");

  // looks back, so a ratio change just after a tick cannot make it fire
  AST_PRESC_DIV4: assert property (@(posedge clk) disable iff (rst) // RULE15
    (t0_int_tick && (t0_prescale_ff == PRESC_DIV4) && ($past(t0_prescale_ff, 1) == PRESC_DIV4) &&
     ($past(t0_prescale_ff, 2) == PRESC_DIV4) && ($past(t0_prescale_ff, 3) == PRESC_DIV4) &&
     ($past(t0_prescale_ff, 4) == PRESC_DIV4))
    |-> $past(t0_int_tick, 4) && !$past(t0_int_tick, 1) && !$past(t0_int_tick, 2) && !$past(t0_int_tick, 3))
    else $error("divide by four spacing wrong");

  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (rst) // RULE9
    irq == ((t0_overflow_flag && mask_ff[STAT_T0_OVF]) || (t1_overflow_flag && mask_ff[STAT_T1_OVF])))
    else $error("interrupt level wrong");
endmodule
`default_nettype wire

// [dv/pin_driver.sv]
// behavioural model of the count inputs and gate pins
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
  // clock
  input wire logic clk,
  // pins toward the timers
  output logic t0_count_pin,
  output logic t1_count_pin,
  output logic external_pin0_qualifier,
  output logic external_pin1_qualifier
);
  // count pins idle high, so each low phase gives one falling edge
  initial
  begin
    t0_count_pin = 1'b1;
    t1_count_pin = 1'b1;
    external_pin0_qualifier = 1'b1;
    external_pin1_qualifier = 1'b1;
  end

  // gap stretches both levels to model a slow source; the tail lets the edge detector settle
  task automatic pulse(input int ch, input int n, input int gap);
    int i;
    for (i = 0; i < n; i++)
    begin
      if (ch == 0)
        t0_count_pin <= 1'b0;
      else
        t1_count_pin <= 1'b0;
      repeat (gap) @(posedge clk);
      if (ch == 0)
        t0_count_pin <= 1'b1;
      else
        t1_count_pin <= 1'b1;
      repeat (gap + 4) @(posedge clk);
    end
  endtask

  task automatic gate(input int ch, input logic v);
    if (ch == 0)
      external_pin0_qualifier <= v;
    else
      external_pin1_qualifier <= v;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
// self-checking testbench for the timer 0/1 block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb
  import timer01_pkg::*;
;
  typedef struct packed {logic [31:0] exp; logic [31:0] msk; logic err;} note_t;
  localparam logic [2:0] F_OFF = 3'h0;
  localparam logic [2:0] F_PIN = 3'h1;
  localparam logic [2:0] F_INT_RUN = 3'h4;
  localparam logic [2:0] F_PIN_RUN = 3'h5;
  localparam logic [2:0] F_PIN_GATE = 3'h3;
  localparam logic [2:0] F_PIN_GATE_RUN = 3'h7;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, t1_baud_tick;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, v, ctrl;
  logic t0_pin, t1_pin, q0_pin, q1_pin;
  note_t notes[$];
  note_t nt;
  int n_fail = 0;
  int checked = 0;
  int n_baud = 0;
  int seed, i, k, n, lo, hi;
  logic ch;

  pin_driver u_pins (.clk(clk), .t0_count_pin(t0_pin), .t1_count_pin(t1_pin),
    .external_pin0_qualifier(q0_pin), .external_pin1_qualifier(q1_pin));
  timer01 #(.ADDR_W(8)) u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .t0_count_pin(t0_pin), .t1_count_pin(t1_pin), .external_pin0_qualifier(q0_pin),
    .external_pin1_qualifier(q1_pin), .irq(irq), .t1_baud_tick(t1_baud_tick));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // read results are matched against the oldest note when the access completes
  always @(posedge clk)
  begin
    if (t1_baud_tick === 1'b1)
      n_baud++;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      `CHK("prdata", nt.exp, prdata & nt.msk)
      `CHK("pslverr", nt.err, pslverr)
    end
  end

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic er);
    logic [31:0] r;
    notes.push_back('{e & m, m, er});
    apb(1'b0, a, 32'h0, r);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] md0, input logic [2:0] f0, input logic [1:0] md1,
    input logic [2:0] f1);
    ctl = 32'h0;
    ctl[CTRL_T0_MODE_LO +: 2] = md0;
    ctl[CTRL_T0_SRC +: 3] = f0;
    ctl[CTRL_T1_MODE_LO +: 2] = md1;
    ctl[CTRL_T1_SRC +: 3] = f1;
  endfunction

  function automatic logic [31:0] cw(input logic [7:0] h, input logic [7:0] l);
    cw = {16'h0, h, l};
  endfunction

  initial
  begin
    seed = 32'h0cc6;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_PRESC, {28'h0, RST_PRESC, RST_PRESC}, 32'hffffffff, 1'b0);
    rd(OFS_CTRL, 32'h0, 32'hffffffff, 1'b0);
    rd(OFS_T1_COUNT, 32'h0, 32'hffffffff, 1'b0);
    wr(8'h18, 32'hffffffff);
    rd(8'h18, 32'h0, 32'hffffffff, 1'b1);
    wr(OFS_MASK, 32'h3);
    wr(OFS_T0_COUNT, cw(8'hff, 8'h1e));
    wr(OFS_CTRL, ctl(MODE_13BIT, F_PIN_RUN, MODE_13BIT, F_OFF));
    u_pins.pulse(0, 1, 1);
    rd(OFS_T0_COUNT, cw(8'hff, 8'h1f), 32'hffff, 1'b0);
    rd(OFS_STATUS, 32'h0, 32'h3, 1'b0);
    u_pins.pulse(0, 1, 3);
    rd(OFS_T0_COUNT, cw(8'h00, 8'h00), 32'hffff, 1'b0);
    rd(OFS_STATUS, 32'h1, 32'h3, 1'b0);
    `CHK("irq_set", 1'b1, irq)
    wr(OFS_STATUS, 32'h1);
    `CHK("irq_clear", 1'b0, irq)
    // random preloads on both timers, last two iterations force the 16-bit wrap
    for (i = 0; i < 6; i++)
    begin
      ch = i[0];
      v = $random(seed);
      n = v[17:16] + 1;
      v = (i >= 4) ? 32'hffff : {17'h0, v[14:0]};
      n = (i >= 4) ? 1 : n;
      ctrl = ch ? ctl(MODE_16BIT, F_OFF, MODE_16BIT, F_PIN_RUN) : ctl(MODE_16BIT, F_PIN_RUN, MODE_16BIT, F_OFF);
      wr(ch ? OFS_T1_COUNT : OFS_T0_COUNT, v);
      wr(OFS_CTRL, ctrl);
      u_pins.pulse(ch, n, 1 + i % 2);
      rd(ch ? OFS_T1_COUNT : OFS_T0_COUNT, v + n, 32'hffff, 1'b0);
      rd(OFS_STATUS, (i >= 4) ? {30'h0, ch, !ch} : 32'h0, 32'h3, 1'b0);
      wr(OFS_STATUS, 32'h3);
    end
    `CHK("baud_count", 1, n_baud)
    wr(OFS_T0_COUNT, cw(8'h80, 8'hfe));
    wr(OFS_CTRL, ctl(MODE_RELOAD, F_PIN_RUN, MODE_13BIT, F_OFF));
    u_pins.pulse(0, 3, 1);
    rd(OFS_T0_COUNT, cw(8'h80, 8'h81), 32'hffff, 1'b0);
    rd(OFS_STATUS, 32'h1, 32'h3, 1'b0);
    wr(OFS_T0_COUNT, 32'h0);
    wr(OFS_CTRL, ctl(MODE_16BIT, F_PIN_GATE_RUN, MODE_13BIT, F_OFF));
    u_pins.gate(0, 1'b0);
    u_pins.pulse(0, 2, 1);
    rd(OFS_T0_COUNT, 32'h0, 32'hffff, 1'b0);
    u_pins.gate(0, 1'b1);
    u_pins.pulse(0, 2, 2);
    rd(OFS_T0_COUNT, 32'h2, 32'hffff, 1'b0);
    wr(OFS_CTRL, ctl(MODE_16BIT, F_PIN_GATE, MODE_13BIT, F_OFF));
    u_pins.pulse(0, 2, 1);
    rd(OFS_T0_COUNT, 32'h2, 32'hffff, 1'b0);
    // count window is about 67 cycles; the bounds leave room for divider phase
    for (i = 0; i < 4; i++)
    begin
      wr(OFS_PRESC, i);
      wr(OFS_T0_COUNT, 32'h0);
      wr(OFS_CTRL, ctl(MODE_16BIT, F_INT_RUN, MODE_13BIT, F_OFF));
      repeat (64) @(posedge clk);
      wr(OFS_CTRL, ctl(MODE_16BIT, F_OFF, MODE_13BIT, F_OFF));
      apb(1'b0, OFS_T0_COUNT, 32'h0, q);
      lo = 64 >> i;
      hi = (70 >> i) + 1;
      `CHK("presc_count", 1'b1, q[15:0] >= lo[15:0] && q[15:0] <= hi[15:0])
    end
    wr(OFS_T1_COUNT, cw(8'h00, 8'h05));
    wr(OFS_CTRL, ctl(MODE_13BIT, F_OFF, MODE_SPLIT, F_PIN_RUN));
    u_pins.pulse(1, 2, 1);
    rd(OFS_T1_COUNT, cw(8'h00, 8'h05), 32'hffff, 1'b0);
    wr(OFS_STATUS, 32'h3);
    wr(OFS_PRESC, 32'h0);
    wr(OFS_T0_COUNT, cw(8'hf0, 8'hff));
    wr(OFS_T1_COUNT, cw(8'hff, 8'hff));
    wr(OFS_CTRL, ctl(MODE_SPLIT, F_PIN_RUN, MODE_16BIT, F_PIN));
    u_pins.pulse(0, 1, 1);
    u_pins.pulse(1, 1, 1);
    rd(OFS_T0_COUNT, cw(8'hf0, 8'h00), 32'hffff, 1'b0);
    rd(OFS_T1_COUNT, 32'h0, 32'hffff, 1'b0);
    rd(OFS_STATUS, 32'h1, 32'h3, 1'b0);
    `CHK("baud_split", 2, n_baud)
    wr(OFS_STATUS, 32'h3);
    wr(OFS_MASK, 32'h2);
    wr(OFS_CTRL, ctl(MODE_SPLIT, F_PIN_RUN, MODE_SPLIT, F_PIN_RUN));
    k = 0;
    while (irq !== 1'b1 && k < 300)
    begin
      @(posedge clk);
      k++;
    end
    `CHK("irq_split", 1'b1, irq)
    if (k >= 300)
      tally_and_finish();
    u_pins.pulse(1, 1, 1);
    rd(OFS_T1_COUNT, 32'h0, 32'hffff, 1'b0);
    wr(OFS_CTRL, ctl(MODE_SPLIT, F_PIN_RUN, MODE_16BIT, F_PIN_RUN));
    u_pins.pulse(1, 1, 2);
    rd(OFS_T1_COUNT, 32'h1, 32'hffff, 1'b0);
    // timer 1 on its own: gate pin and auto-reload, then masking of its flag
    wr(OFS_T1_COUNT, cw(8'h40, 8'hff));
    wr(OFS_CTRL, ctl(MODE_13BIT, F_OFF, MODE_RELOAD, F_PIN_GATE_RUN));
    wr(OFS_STATUS, 32'h3);
    u_pins.gate(1, 1'b0);
    u_pins.pulse(1, 1, 1);
    rd(OFS_T1_COUNT, cw(8'h40, 8'hff), 32'hffff, 1'b0);
    u_pins.gate(1, 1'b1);
    u_pins.pulse(1, 2, 1);
    rd(OFS_T1_COUNT, cw(8'h40, 8'h41), 32'hffff, 1'b0);
    rd(OFS_STATUS, 32'h2, 32'h3, 1'b0);
    `CHK("irq_t1", 1'b1, irq)
    wr(OFS_MASK, 32'h1);
    `CHK("irq_masked", 1'b0, irq)
    `CHK("baud_reload", 3, n_baud)
    tally_and_finish();
  end
endmodule
`default_nettype wire
